// ===== debounce_bank.sv
// one debounce filter per input, each with its own setting and count
// assumes raw inputs are already synchronised to clk_i
`timescale 1ns/1ps
module debounce_bank
  import terminal_mux_pkg::*;
#(
  parameter int NCH = NUM_FILT
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  filter_if.bank    fi
);
  typedef struct packed {
    logic [CUST_W-1:0] cnt;
    logic              out;
  } chan_t;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
    chan_t             s_q;
    chan_t             s_d;
    logic [CUST_W-1:0] n_eff;
    logic              en;
    logic              tick;

    always_comb begin
      // sample count per setting, held per channel
      case (fi.mode[ch])
        MODE_SHORT:  n_eff = N_SHORT;
        MODE_MEDIUM: n_eff = N_MEDIUM;
        MODE_HIGH:   n_eff = N_HIGH;
        MODE_CUSTOM: n_eff = (fi.custom[ch] == '0) ? 16'h0001 : fi.custom[ch];
        default:     n_eff = 16'h0001;
      endcase
    end

    assign en   = (fi.mode[ch] >= MODE_SHORT) && (fi.mode[ch] <= MODE_CUSTOM);
    assign tick = (fi.mode[ch] == MODE_HIGH) ? fi.tick_slow : fi.tick_fast;

    always_comb begin
      s_d = s_q;
      if (!en) begin
        s_d.out = fi.raw[ch];
        s_d.cnt = '0;
      end else if (tick) begin
        if (fi.raw[ch] == s_q.out) begin
          s_d.cnt = '0;
        end else if (s_q.cnt >= n_eff - 1'b1) begin
          s_d.out = fi.raw[ch];
          s_d.cnt = '0;
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        s_q <= '0;
      end else begin
        s_q <= s_d;
      end
    end

    // bypass when off, else output follows raw after n_eff differing samples on ticks
    assign fi.filt[ch] = en ? s_q.out : fi.raw[ch];

    bypass_pass_a: assert property (
      !en |-> fi.filt[ch] == fi.raw[ch]) else $error("bypass does not follow raw");
    pass_count_a: assert property (
      en && $stable(fi.mode[ch]) && $changed(s_q.out)
      |-> $past(tick) && ($past(s_q.cnt) == $past(n_eff) - 1'b1))
      else $error("filter passed without full count");
    count_restart_a: assert property (
      en && tick && (fi.raw[ch] == s_q.out) |=> s_q.cnt == '0)
      else $error("matching sample did not restart count");
    tick_only_a: assert property (
      en && !tick |=> $stable(s_q.out) && $stable(s_q.cnt))
      else $error("filter changed between ticks");
  end
endmodule

// ===== filter_if.sv
// carrier between the register side, the tick source and the filter bank
// assumes all parties run on the same system clock
`timescale 1ns/1ps
interface filter_if
  import terminal_mux_pkg::*;
#(
  parameter int NCH = NUM_FILT
);
  logic [NCH-1:0]             raw;
  logic [NCH-1:0][MODE_W-1:0] mode;
  logic [NCH-1:0][CUST_W-1:0] custom;
  logic [NCH-1:0]             filt;
  logic                       tick_fast;
  logic                       tick_slow;

  modport ctrl   (output raw, mode, custom, input filt, tick_fast, tick_slow);
  modport bank   (input raw, mode, custom, tick_fast, tick_slow, output filt);
  modport ticker (output tick_fast, tick_slow);
endinterface

// ===== filter_tick_gen.sv
// filter clock ticks derived from the system clock
// assumes a synchronous active-high reset
`timescale 1ns/1ps
module filter_tick_gen
  import terminal_mux_pkg::*;
#(
  parameter int FAST_DIV_P = FAST_DIV,
  parameter int SLOW_DIV_P = SLOW_DIV
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  filter_if.ticker  fi
);
  typedef struct packed {
    logic [DIV_W-1:0] fast_cnt;
    logic [DIV_W-1:0] slow_cnt;
  } tick_state_t;

  tick_state_t s_q;
  tick_state_t s_d;

  // fast tick for short, medium and custom, slow tick for high
  assign fi.tick_fast = (s_q.fast_cnt == DIV_W'(FAST_DIV_P - 1));
  assign fi.tick_slow = (s_q.slow_cnt == DIV_W'(SLOW_DIV_P - 1));

  always_comb begin
    s_d = s_q;
    s_d.fast_cnt = fi.tick_fast ? '0 : s_q.fast_cnt + 1'b1;
    s_d.slow_cnt = fi.tick_slow ? '0 : s_q.slow_cnt + 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// ===== function_terminal_mux_debounce.sv
// forty function terminals: static ports, routed timing inputs, exported
// timing outputs, change detection and per-input debounce filters
// assumes an AXI4-Lite master on clk_i and pins synchronised here
//
// Operation
// - forty terminals, each configured on its own
// - each terminal takes one of four roles
// - timing role uses index 0..39, static role uses a port bit
// - any terminal routable to every counter and capture/pattern timing input
// - routed inputs have selectable polarity and edge or level sense
// - output terminals carry any listed internal or trigger signal
// - exported pattern sample clock is inverted, others not
// - each terminal can flag changes as an internal event
// - debounce filter on every terminal and trigger input
// - enabled filter samples only on filter clock ticks
// - rising change passes after N matching samples, glitches restart
// - falling change handled the same way
// - N is 9, 512, 256 or custom, none bypasses
// - filter clock is fast for short and medium, slow for high
// - filter setting and count held per input
// - filters disabled after reset
// - filter adds at most one tick period of jitter
// - system and PXI trigger lines routed to terminals are forwarded unfiltered, PXI star after its filter
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module function_terminal_mux_debounce
  import terminal_mux_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   awvalid_i,
  output logic                        awready_o,
  input  wire logic [ADDR_W-1:0]      awaddr_i,
  input  wire logic                   wvalid_i,
  output logic                        wready_o,
  input  wire logic [31:0]            wdata_i,
  input  wire logic [3:0]             wstrb_i,
  output logic                        bvalid_o,
  input  wire logic                   bready_i,
  output logic [1:0]                  bresp_o,
  input  wire logic                   arvalid_i,
  output logic                        arready_o,
  input  wire logic [ADDR_W-1:0]      araddr_i,
  output logic                        rvalid_o,
  input  wire logic                   rready_i,
  output logic [31:0]                 rdata_o,
  output logic [1:0]                  rresp_o,
  input  wire logic [NUM_TERM-1:0]    term_i,
  output logic [NUM_TERM-1:0]         term_o,
  output logic [NUM_TERM-1:0]         term_oe_o,
  input  wire logic [NUM_TRIG-1:0]    sys_trig_i,
  input  wire logic [NUM_TRIG-1:0]    pxi_trig_i,
  input  wire logic                   pxi_star_i,
  input  wire logic [1:0]             diff_star_i,
  input  wire logic [NUM_CAP_PAT-1:0] cap_pat_i,
  input  wire logic [NUM_CTR-1:0]     ctr_source_i,
  input  wire logic [NUM_CTR-1:0]     ctr_gate_i,
  input  wire logic [NUM_CTR-1:0]     ctr_out_i,
  input  wire logic [NUM_CTR-1:0]     ctr_sample_clk_i,
  input  wire logic [NUM_CTR-1:0]     ctr_arm_i,
  input  wire logic                   freq_out_i,
  output logic [NUM_DEST-1:0]         dest_o,
  output logic [NUM_FILT-NUM_TERM-1:0] trig_filt_o,
  output logic                        change_event_o
);
  typedef struct packed {
    logic [NUM_FILT-1:0]                     sync1;
    logic [NUM_FILT-1:0]                     sync2;
    logic [NUM_PORT_A-1:0]                   port_a;
    logic [NUM_TERM-NUM_PORT_A-1:0]          port_b;
    logic [NUM_TERM-1:0][TC_W-1:0]           term_cfg;
    logic [NUM_FILT-1:0][MODE_W-1:0]         filt_mode;
    logic [NUM_FILT-1:0][CUST_W-1:0]         filt_cust;
    logic [NUM_DEST-1:0][RC_W-1:0]           route_cfg;
    logic                                    aw_ok;
    logic [ADDR_W-1:0]                       awaddr;
    logic                                    w_ok;
    logic [31:0]                             wdata;
    logic [3:0]                              wstrb;
    logic                                    bvalid;
    logic [1:0]                              bresp;
    logic                                    rvalid;
    logic [31:0]                             rdata;
    logic [1:0]                              rresp;
    logic [NUM_TERM-1:0]                     term_out;
    logic [NUM_TERM-1:0]                     term_oe;
    logic [NUM_DEST-1:0]                     dest;
    logic [NUM_DEST-1:0]                     dest_prev;
    logic [NUM_TERM-1:0]                     filt_prev;
    logic [NUM_FILT-NUM_TERM-1:0]            trig_filt;
    logic                                    change;
  } top_state_t;

  top_state_t          s_q;
  top_state_t          s_d;
  logic [NUM_SRC-1:0]  src;
  logic [NUM_TERM-1:0] tfilt;

  filter_if #(.NCH(NUM_FILT)) fi ();

  filter_tick_gen u_ticks (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .fi    (fi.ticker)
  );

  debounce_bank #(.NCH(NUM_FILT)) u_bank (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .fi    (fi.bank)
  );

  assign fi.raw    = s_q.sync2;
  assign fi.mode   = s_q.filt_mode;
  assign fi.custom = s_q.filt_cust;
  assign tfilt     = fi.filt[NUM_TERM-1:0];

  // exportable sources; system and PXI trigger lines taken before their filters, PXI star after its filter
  assign src = {s_q.change,
                s_q.sync2[FI_STAR-1:FI_PXI_TRIG],
                fi.filt[FI_STAR],
                s_q.sync2[FI_PXI_TRIG-1:FI_SYS_TRIG],
                freq_out_i, ctr_arm_i, ctr_sample_clk_i, ctr_out_i,
                ctr_gate_i, ctr_source_i, cap_pat_i};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic dec_t decode(input logic [ADDR_W-1:0] a);
    dec_t              r;
    logic [ADDR_W-1:0] off;
    r.kind = K_NONE;
    r.idx  = '0;
    off    = '0;
    if (a[1:0] != 2'h0) begin
      r.kind = K_NONE;
    end else if (a == OFF_PORT_A_OUT) begin
      r.kind = K_A_OUT;
    end else if (a == OFF_PORT_B_OUT) begin
      r.kind = K_B_OUT;
    end else if (a == OFF_PORT_A_IN) begin
      r.kind = K_A_IN;
    end else if (a == OFF_PORT_B_IN) begin
      r.kind = K_B_IN;
    end else if (a >= OFF_TERM_BASE && a < OFF_TERM_END) begin
      off    = a - OFF_TERM_BASE;
      r.kind = K_TERM;
      r.idx  = off[8:2];
    end else if (a >= OFF_FILT_BASE && a < OFF_FILT_END) begin
      off    = a - OFF_FILT_BASE;
      r.kind = K_FILT;
      r.idx  = off[8:2];
    end else if (a >= OFF_ROUTE_BASE && a < OFF_ROUTE_END) begin
      off    = a - OFF_ROUTE_BASE;
      r.kind = K_ROUTE;
      r.idx  = off[8:2];
    end
    return r;
  endfunction

  assign awready_o = !s_q.aw_ok && !s_q.bvalid;
  assign wready_o  = !s_q.w_ok && !s_q.bvalid;
  assign arready_o = !s_q.rvalid;

  always_comb begin
    dec_t              wd;
    dec_t              rd;
    logic [31:0]       mw;
    logic [ROLE_W-1:0] role;
    logic [SEL_W-1:0]  sel;
    logic [TSEL_W-1:0] tsel;
    logic              val;
    logic              v;
    wd   = decode(s_q.awaddr);
    rd   = decode(araddr_i);
    mw   = '0;
    role = ROLE_STATIC_IN;
    sel  = '0;
    tsel = '0;
    val  = 1'b0;
    v    = 1'b0;
    s_d  = s_q;

    // two-stage synchroniser for every pin input
    s_d.sync1 = {diff_star_i, pxi_star_i, pxi_trig_i, sys_trig_i, term_i};
    s_d.sync2 = s_q.sync1;
    s_d.trig_filt = fi.filt[NUM_FILT-1:NUM_TERM];

    // write channel
    if (awvalid_i && awready_o) begin
      s_d.aw_ok  = 1'b1;
      s_d.awaddr = awaddr_i;
    end
    if (wvalid_i && wready_o) begin
      s_d.w_ok  = 1'b1;
      s_d.wdata = wdata_i;
      s_d.wstrb = wstrb_i;
    end
    if (s_q.aw_ok && s_q.w_ok) begin
      s_d.aw_ok  = 1'b0;
      s_d.w_ok   = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = (wd.kind == K_NONE) ? RESP_SLVERR : RESP_OKAY;
      case (wd.kind)
        K_A_OUT: s_d.port_a = merge(s_q.port_a, s_q.wdata, s_q.wstrb);
        K_B_OUT: begin
          mw = merge({24'h0, s_q.port_b}, s_q.wdata, s_q.wstrb);
          s_d.port_b = mw[7:0];
        end
        K_TERM: begin
          mw = merge({21'h0, s_q.term_cfg[wd.idx]}, s_q.wdata, s_q.wstrb);
          s_d.term_cfg[wd.idx] = mw[TC_W-1:0];
        end
        K_FILT: begin
          mw = merge({s_q.filt_cust[wd.idx], 13'h0, s_q.filt_mode[wd.idx]},
                     s_q.wdata, s_q.wstrb);
          s_d.filt_mode[wd.idx] = mw[FC_MODE_LSB +: MODE_W];
          s_d.filt_cust[wd.idx] = mw[FC_CUST_LSB +: CUST_W];
        end
        K_ROUTE: begin
          mw = merge({24'h0, s_q.route_cfg[wd.idx]}, s_q.wdata, s_q.wstrb);
          s_d.route_cfg[wd.idx] = mw[RC_W-1:0];
        end
        default: s_d.bresp = s_d.bresp;
      endcase
    end
    if (s_q.bvalid && bready_i) begin
      s_d.bvalid = 1'b0;
    end

    // read channel
    if (arvalid_i && arready_o) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = RESP_OKAY;
      case (rd.kind)
        K_A_OUT: s_d.rdata = s_q.port_a;
        K_B_OUT: s_d.rdata = {24'h0, s_q.port_b};
        K_A_IN:  s_d.rdata = tfilt[NUM_PORT_A-1:0];
        K_B_IN:  s_d.rdata = {24'h0, tfilt[NUM_TERM-1:NUM_PORT_A]};
        K_TERM:  s_d.rdata = {21'h0, s_q.term_cfg[rd.idx]};
        K_FILT:  s_d.rdata = {s_q.filt_cust[rd.idx], 13'h0, s_q.filt_mode[rd.idx]};
        K_ROUTE: s_d.rdata = {24'h0, s_q.route_cfg[rd.idx]};
        default: begin
          s_d.rdata = '0;
          s_d.rresp = RESP_SLVERR;
        end
      endcase
    end else if (s_q.rvalid && rready_i) begin
      s_d.rvalid = 1'b0;
    end

    // per-terminal role, driver and change detection
    s_d.change = 1'b0;
    for (int t = 0; t < NUM_TERM; t++) begin
      role = s_q.term_cfg[t][TC_ROLE_LSB +: ROLE_W];
      sel  = s_q.term_cfg[t][TC_SEL_LSB +: SEL_W];
      val  = 1'b0;
      if (role == ROLE_STATIC_OUT) begin
        val = (t < NUM_PORT_A) ? s_q.port_a[t] : s_q.port_b[t - NUM_PORT_A];
      end else if (role == ROLE_TIMING_OUT && sel < SEL_W'(NUM_SRC)) begin
        val = src[sel] ^ (sel == SRC_OP_SAMPLE_CLK);
      end
      s_d.term_oe[t]  = (role == ROLE_STATIC_OUT) || (role == ROLE_TIMING_OUT);
      s_d.term_out[t] = s_d.term_oe[t] & val;
      if ((s_q.term_cfg[t][TC_RISE_BIT] && tfilt[t] && !s_q.filt_prev[t]) ||
          (s_q.term_cfg[t][TC_FALL_BIT] && !tfilt[t] && s_q.filt_prev[t])) begin
        s_d.change = 1'b1;
      end
    end
    s_d.filt_prev = tfilt;

    // timing input routing by terminal index
    for (int d = 0; d < NUM_DEST; d++) begin
      tsel = s_q.route_cfg[d][RC_SEL_LSB +: TSEL_W];
      v    = (tsel < TSEL_W'(NUM_TERM)) ? tfilt[tsel] : 1'b0;
      v    = v ^ s_q.route_cfg[d][RC_INV_BIT];
      s_d.dest_prev[d] = v;
      s_d.dest[d] = s_q.route_cfg[d][RC_EDGE_BIT] ? (v && !s_q.dest_prev[d]) : v;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bvalid_o       = s_q.bvalid;
  assign bresp_o        = s_q.bresp;
  assign rvalid_o       = s_q.rvalid;
  assign rdata_o        = s_q.rdata;
  assign rresp_o        = s_q.rresp;
  assign term_o         = s_q.term_out;
  assign term_oe_o      = s_q.term_oe;
  assign dest_o         = s_q.dest;
  assign trig_filt_o    = s_q.trig_filt;
  assign change_event_o = s_q.change;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence term_timing_out(int t, logic [SEL_W-1:0] s);
    s_q.term_cfg[t][TC_ROLE_LSB +: ROLE_W] == ROLE_TIMING_OUT &&
    s_q.term_cfg[t][TC_SEL_LSB +: SEL_W] == s;
  endsequence

  sequence d0_route(logic edge_m);
    s_q.route_cfg[0][RC_EDGE_BIT] == edge_m && $stable(s_q.route_cfg[0]);
  endsequence

  pattern_inv_a: assert property (
    term_timing_out(39, SRC_OP_SAMPLE_CLK) |=> term_o[39] == !$past(cap_pat_i[4]))
    else $error("pattern clock not inverted");
  raw_forward_a: assert property (
    term_timing_out(38, SRC_SYS_TRIG_BASE) |=> term_o[38] == $past(s_q.sync2[FI_SYS_TRIG]))
    else $error("trigger line not forwarded raw");
  static_map_a: assert property (
    s_q.term_cfg[32][TC_ROLE_LSB +: ROLE_W] == ROLE_STATIC_OUT
    |=> term_o[32] == $past(s_q.port_b[0])) else $error("port b bit 0 not on terminal 32");
  rest_low_a: assert property (
    (term_o & ~term_oe_o) == '0) else $error("undriven terminal not low");
  dir_ctrl_a: assert property (
    s_q.term_cfg[1][TC_ROLE_LSB +: ROLE_W] == ROLE_TIMING_IN |=> !term_oe_o[1])
    else $error("input terminal driven");
  edge_single_a: assert property (
    (dest_o[0] and d0_route(1'b1)) |=> !dest_o[0]) else $error("edge pulse too long");
  level_pass_a: assert property (
    (d0_route(1'b0) and (s_q.route_cfg[0][RC_SEL_LSB +: TSEL_W] == TSEL_W'(1)))
    |=> dest_o[0] == $past(tfilt[1] ^ s_q.route_cfg[0][RC_INV_BIT]))
    else $error("level route mismatch");
  change_flag_a: assert property (
    s_q.term_cfg[1][TC_RISE_BIT] && $rose(tfilt[1]) |=> change_event_o)
    else $error("change event missed");
  write_resp_a: assert property (
    awvalid_i && awready_o && wvalid_i && wready_o |-> ##2 bvalid_o)
    else $error("write response late");
  read_resp_a: assert property (
    arvalid_i && arready_o |=> rvalid_o) else $error("read response late");
endmodule

// ===== pin_far_end.sv
// far-end model: external sources and loads on the terminals
// assumes the testbench sets ext_val_i and ext_en_i
`timescale 1ns/1ps
module pin_far_end (
  input  wire logic [39:0] pin_drv_i,
  input  wire logic [39:0] pin_oe_i,
  input  wire logic [39:0] ext_val_i,
  input  wire logic [39:0] ext_en_i,
  output logic      [39:0] pin_o
);
  // undriven line rests low through the pull-down
  assign pin_o = (pin_oe_i & pin_drv_i) | (~pin_oe_i & ext_en_i & ext_val_i);
endmodule

// ===== terminal_mux_pkg.sv
// constants and types for the function terminal mux and debounce block
// assumes a 10 MHz system clock and a 32-bit AXI4-Lite register bus
package terminal_mux_pkg;

  localparam int NUM_TERM     = 40;
  localparam int NUM_PORT_A   = 32;
  localparam int NUM_TRIG     = 8;
  localparam int NUM_FILT     = 59;
  localparam int NUM_DEST     = 68;
  localparam int NUM_SRC      = 66;
  localparam int NUM_CTR      = 8;
  localparam int NUM_CAP_PAT  = 7;
  localparam int ADDR_W       = 12;
  localparam int SEL_W        = 7;
  localparam int TSEL_W       = 6;
  localparam int CUST_W       = 16;
  localparam int MODE_W       = 3;
  localparam int ROLE_W       = 2;
  localparam int DIV_W        = 16;

  // filter input indices
  localparam int FI_SYS_TRIG  = 40;
  localparam int FI_PXI_TRIG  = 48;
  localparam int FI_STAR      = 56;
  localparam int FI_DSTAR     = 57;

  // terminal roles
  localparam logic [ROLE_W-1:0] ROLE_STATIC_IN  = 2'h0;
  localparam logic [ROLE_W-1:0] ROLE_STATIC_OUT = 2'h1;
  localparam logic [ROLE_W-1:0] ROLE_TIMING_IN  = 2'h2;
  localparam logic [ROLE_W-1:0] ROLE_TIMING_OUT = 2'h3;

  // filter settings and sample counts
  localparam logic [MODE_W-1:0] MODE_NONE   = 3'h0;
  localparam logic [MODE_W-1:0] MODE_SHORT  = 3'h1;
  localparam logic [MODE_W-1:0] MODE_MEDIUM = 3'h2;
  localparam logic [MODE_W-1:0] MODE_HIGH   = 3'h3;
  localparam logic [MODE_W-1:0] MODE_CUSTOM = 3'h4;
  localparam logic [CUST_W-1:0] N_SHORT     = 16'h0009;
  localparam logic [CUST_W-1:0] N_MEDIUM    = 16'h0200;
  localparam logic [CUST_W-1:0] N_HIGH      = 16'h0100;

  // clock rates in Hz and derived tick dividers
  localparam int CLK_HZ       = 32'h0098_9680;
  localparam int FILT_FAST_HZ = 32'h05F5_E100;
  localparam int FILT_SLOW_HZ = 32'h0001_86A0;
  localparam int FAST_DIV     = (CLK_HZ / FILT_FAST_HZ < 1) ? 1 : CLK_HZ / FILT_FAST_HZ;
  localparam int SLOW_DIV     = (CLK_HZ / FILT_SLOW_HZ < 1) ? 1 : CLK_HZ / FILT_SLOW_HZ;

  // field layouts
  localparam int TC_ROLE_LSB  = 0;
  localparam int TC_SEL_LSB   = 2;
  localparam int TC_RISE_BIT  = 9;
  localparam int TC_FALL_BIT  = 10;
  localparam int TC_W         = 11;
  localparam int FC_MODE_LSB  = 0;
  localparam int FC_CUST_LSB  = 16;
  localparam int RC_SEL_LSB   = 0;
  localparam int RC_INV_BIT   = 6;
  localparam int RC_EDGE_BIT  = 7;
  localparam int RC_W         = 8;

  // output source indices
  localparam logic [SEL_W-1:0] SRC_OP_SAMPLE_CLK = 7'h04;
  localparam logic [SEL_W-1:0] SRC_SYS_TRIG_BASE = 7'h30;

  // register map
  localparam logic [ADDR_W-1:0] OFF_PORT_A_OUT = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_PORT_B_OUT = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_PORT_A_IN  = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_PORT_B_IN  = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_TERM_BASE  = 12'h100;
  localparam logic [ADDR_W-1:0] OFF_FILT_BASE  = 12'h200;
  localparam logic [ADDR_W-1:0] OFF_ROUTE_BASE = 12'h300;
  localparam logic [ADDR_W-1:0] OFF_TERM_END   = OFF_TERM_BASE + 12'(4 * NUM_TERM);
  localparam logic [ADDR_W-1:0] OFF_FILT_END   = OFF_FILT_BASE + 12'(4 * NUM_FILT);
  localparam logic [ADDR_W-1:0] OFF_ROUTE_END  = OFF_ROUTE_BASE + 12'(4 * NUM_DEST);

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    K_NONE  = 3'h0,
    K_A_OUT = 3'h1,
    K_B_OUT = 3'h2,
    K_A_IN  = 3'h3,
    K_B_IN  = 3'h4,
    K_TERM  = 3'h5,
    K_FILT  = 3'h6,
    K_ROUTE = 3'h7
  } reg_kind_t;

  typedef struct packed {
    reg_kind_t  kind;
    logic [6:0] idx;
  } dec_t;

endpackage

// ===== testbench.sv
// self-checking bench for the function terminal mux and debounce block
// assumes the far-end pin model and a 10 MHz clock
`timescale 1ns/1ps
module testbench;
  import terminal_mux_pkg::*;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} row_t;
  logic        clk_i = 0, rst_i = 1, clr = 0;
  logic        awvalid_i = 0, wvalid_i = 0, bready_i = 0, arvalid_i = 0, rready_i = 0;
  logic [11:0] awaddr_i = '0, araddr_i = '0;
  logic [31:0] wdata_i = '0, rdv, rdata_o;
  logic [1:0]  rsp, bresp_o, rresp_o, seen = '0;
  logic [39:0] term_i, term_o, term_oe_o, ext_val = '0, ext_en = '0;
  logic [7:0]  src = '0;
  logic [6:0]  cap_pat = '0;
  logic [67:0] dest_o;
  logic [18:0] trig_filt;
  logic        awready_o, wready_o, bvalid_o, arready_o, rvalid_o, change_event_o;
  int          err_count = 0, check_count = 0;
  row_t rows[12] = '{
    '{12'h104, 32'h202, 32'h202, RESP_OKAY}, '{12'h19C, 32'h13, 32'h13, RESP_OKAY},
    '{12'h204, 32'h5_0004, 32'h5_0004, RESP_OKAY}, '{12'h300, 32'h1, 32'h1, RESP_OKAY},
    '{12'h100, 32'h1, 32'h1, RESP_OKAY}, '{12'h180, 32'h1, 32'h1, RESP_OKAY},
    '{12'h198, 32'hC3, 32'hC3, RESP_OKAY}, '{12'h2A0, 32'h3, 32'h3, RESP_OKAY},
    '{12'h208, 32'h1, 32'h1, RESP_OKAY}, '{12'h20C, 32'h2, 32'h2, RESP_OKAY},
    '{12'h210, 32'h0, 32'h0, RESP_OKAY}, '{12'hFFC, 32'h1, 32'h0, RESP_SLVERR}};

  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) seen <= clr ? 2'b00 : seen | {change_event_o, dest_o[0]};

  function_terminal_mux_debounce i_function_terminal_mux_debounce (.clk_i, .rst_i,
    .awvalid_i, .awready_o, .awaddr_i, .wvalid_i, .wready_o, .wdata_i, .wstrb_i(4'hF),
    .bvalid_o, .bready_i, .bresp_o, .arvalid_i, .arready_o, .araddr_i, .rvalid_o,
    .rready_i, .rdata_o, .rresp_o, .term_i, .term_o, .term_oe_o, .sys_trig_i(src),
    .pxi_trig_i(src), .pxi_star_i(src[0]), .diff_star_i(src[1:0]), .cap_pat_i(cap_pat),
    .ctr_source_i(src), .ctr_gate_i(src), .ctr_out_i(src), .ctr_sample_clk_i(src),
    .ctr_arm_i(src), .freq_out_i(src[0]), .dest_o, .trig_filt_o(trig_filt), .change_event_o);
  pin_far_end i_pin_far_end (.pin_drv_i(term_o), .pin_oe_i(term_oe_o), .ext_val_i(ext_val),
    .ext_en_i(ext_en), .pin_o(term_i));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    awaddr_i <= a;
    wdata_i <= d;
    awvalid_i <= 1;
    wvalid_i <= 1;
    bready_i <= 1;
    do begin
      @(posedge clk_i);
      if (awready_o) awvalid_i <= 0;
      if (wready_o) wvalid_i <= 0;
    end while (!bvalid_o);
    bready_i <= 0;
    rsp = bresp_o;
  endtask
  task automatic rd_reg(input logic [11:0] a);
    @(posedge clk_i);
    araddr_i <= a;
    arvalid_i <= 1;
    rready_i <= 1;
    do begin
      @(posedge clk_i);
      if (arready_o) arvalid_i <= 0;
    end while (!rvalid_o);
    rready_i <= 0;
    rdv = rdata_o;
    rsp = rresp_o;
  endtask
  task automatic pulse(input int n);
    @(posedge clk_i);
    clr <= 0;
    ext_val[1] <= 1;
    repeat (n) @(posedge clk_i);
    ext_val[1] <= 0;
    repeat (20) @(posedge clk_i);
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    ext_en <= 40'h00_0000_0002;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      chk(32'(rsp), 32'(rows[i].r));
      rd_reg(rows[i].a);
      chk(rdv, rows[i].e);
      chk(32'(rsp), 32'(rows[i].r));
    end
    wr(OFF_PORT_A_OUT, 32'h1);
    wr(OFF_PORT_B_OUT, 32'h1);
    repeat (3) @(posedge clk_i);
    chk(32'({term_oe_o[32], term_o[32], term_oe_o[0], term_o[0], term_oe_o[1]}), 32'h1E);
    chk(32'(term_o[39]), 32'h1);
    cap_pat <= 7'h10;
    src <= 8'h01;
    repeat (4) @(posedge clk_i);
    chk(32'({term_o[39], term_o[38]}), 32'h1);
    chk(32'(trig_filt[0]), 32'h0);
    clr <= 1;
    pulse(4);
    chk(32'(seen), 32'h0);
    clr <= 1;
    pulse(5);
    chk(32'(seen), 32'h3);
    chk(32'(dest_o[0]), 32'h0);
    wr(OFF_ROUTE_BASE, 32'h81);
    clr <= 1;
    pulse(5);
    chk(32'(seen), 32'h3);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    chk(32'(|term_oe_o), 32'h0);
    rd_reg(12'h204);
    chk(rdv, 32'h0);
    test_done;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    test_done;
  end
endmodule
